// File: hw/dsm_pkg.sv
// What this block does
// [RL1] Bit 15 set while settings are written
// [RL2] Bit 12 set under communications control
// [RL3] Bit 11 set while alarm active
// [RL4] Bit 8 set under current limiting
// [RL5] Bit 7 set under voltage limiting
// [RL6] Bit 5 set above undervoltage threshold
// [RL7] Bit 3 set while output stopped
// [RL8] Bit 2 set during DC braking
// [RL9] Bit 1 set running reverse
// [RL10] Bit 0 set running forward
// [RL11] Bit 10 decelerating, bit 9 accelerating
// [RL12] Bits 14, 13, 6, 4 always zero
// [RL13] Status item shows word as hex, MSB left
// [RL14] Item 0 shows frequency before slip compensation
// [RL15] Item 1 shows frequency after slip compensation
// [RL16] Item 6 shows F, R or dashes
// [RL17] Item 9 shows frequency times speed coefficient
// [RL18] Speed of 10000 or more shows overflow
// [RL19] Item 10 shows scaled PID command, dashes if off
// [RL20] Item 11 shows scaled PID feedback, dashes if off
// [RL21] Monitor offered only in full-menu mode 2
// [RL22] Hex digits use glyphs 0-9 A b C d E F
package dsm_pkg;
   // APB register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_SPEED_COEF = 8'h04;
   localparam logic [7:0] REG_PID_A = 8'h08;
   localparam logic [7:0] REG_PID_B = 8'h0c;
   localparam logic [7:0] REG_UV_THRESH = 8'h10;
   localparam logic [7:0] REG_STATUS = 8'h14;
   localparam logic [7:0] REG_DISPLAY = 8'h18;
   // Control register fields
   localparam int CTRL_MENU_LSB = 0;
   localparam int CTRL_ITEM_LSB = 8;
   // Reset values
   localparam logic [1:0] RST_MENU = 2'h0;
   localparam logic [3:0] RST_ITEM = 4'h0;
   localparam logic [15:0] RST_SPEED_COEF = 16'h0001;
   localparam logic [15:0] RST_PID_A = 16'h0064;
   localparam logic [15:0] RST_PID_B = 16'h0000;
   localparam logic [15:0] RST_UV_THRESH = 16'h00c8;
   // Menu limit value that opens the monitor
   localparam logic [1:0] MENU_FULL = 2'h2;
   // Monitoring item codes
   localparam logic [3:0] ITEM_FREQ_PRE = 4'h0;
   localparam logic [3:0] ITEM_FREQ_POST = 4'h1;
   localparam logic [3:0] ITEM_DIRECTION = 4'h6;
   localparam logic [3:0] ITEM_STATUS = 4'h7;
   localparam logic [3:0] ITEM_SPEED = 4'h9;
   localparam logic [3:0] ITEM_PID_CMD = 4'ha;
   localparam logic [3:0] ITEM_PID_FB = 4'hb;
   // Status word bit positions
   localparam int BIT_BUSY = 15;
   localparam int BIT_REMOTE = 12;
   localparam int BIT_FAULT = 11;
   localparam int BIT_DOWN = 10;
   localparam int BIT_UP = 9;
   localparam int BIT_ILIM = 8;
   localparam int BIT_VLIM = 7;
   localparam int BIT_VOK = 5;
   localparam int BIT_STOP = 3;
   localparam int BIT_DCBRK = 2;
   localparam int BIT_REV = 1;
   localparam int BIT_FWD = 0;
   // Smallest value that no longer fits four decimal digits, and PID fraction shift
   localparam logic [31:0] DISP_LIMIT = 32'h0000_2710;
   localparam int PID_FRAC = 15;
   // Glyph codes: 0..15 are hex digits
   localparam logic [4:0] GLY_DASH = 5'h10;
   localparam logic [4:0] GLY_R = 5'h11;
   localparam logic [4:0] GLY_BLANK = 5'h12;
   localparam logic [4:0] GLY_OVF = 5'h13;
   localparam logic [4:0] GLY_F = 5'h0f;

   // Segment pattern, bit order g f e d c b a
   function automatic logic [6:0] dsm_seg(input logic [4:0] g);
      case (g)
         5'h00: dsm_seg = 7'h3f;
         5'h01: dsm_seg = 7'h06;
         5'h02: dsm_seg = 7'h5b;
         5'h03: dsm_seg = 7'h4f;
         5'h04: dsm_seg = 7'h66;
         5'h05: dsm_seg = 7'h6d;
         5'h06: dsm_seg = 7'h7d;
         5'h07: dsm_seg = 7'h07;
         5'h08: dsm_seg = 7'h7f;
         5'h09: dsm_seg = 7'h6f;
         5'h0a: dsm_seg = 7'h77;
         5'h0b: dsm_seg = 7'h7c;
         5'h0c: dsm_seg = 7'h39;
         5'h0d: dsm_seg = 7'h5e;
         5'h0e: dsm_seg = 7'h79;
         5'h0f: dsm_seg = 7'h71;
         5'h10: dsm_seg = 7'h40;
         5'h11: dsm_seg = 7'h50;
         5'h13: dsm_seg = 7'h49;
         default: dsm_seg = 7'h00;
      endcase
   endfunction : dsm_seg
endpackage : dsm_pkg

// File: hw/dsm_drive_status_monitor.sv
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module dsm_drive_status_monitor
   import dsm_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic remote_link_active,
   input wire logic fault_active,
   input wire logic ramping_down,
   input wire logic ramping_up,
   input wire logic current_limit_active,
   input wire logic voltage_limit_active,
   input wire logic output_stopped,
   input wire logic dc_brake_active,
   input wire logic running_backward,
   input wire logic running_ahead,
   input wire logic [15:0] dc_link_volts,
   input wire logic [15:0] freq_pre_slip,
   input wire logic [15:0] freq_post_slip,
   input wire logic pid_enabled,
   input wire logic [15:0] pid_command,
   input wire logic [15:0] pid_feedback,
   output logic [15:0] running_status,
   output logic monitor_available,
   output logic [19:0] led_glyphs,
   output logic [27:0] led_segments
);

   // Binary to four BCD digits by shift and add-three
   function automatic logic [15:0] dsm_bcd(input logic [13:0] v);
      logic [29:0] s;
      s = {16'h0000, v};
      for (int i = 0; i < 14; i++) begin
         for (int n = 0; n < 4; n++) begin
            if (s[14 + 4 * n +: 4] >= 4'h5) begin
               s[14 + 4 * n +: 4] = s[14 + 4 * n +: 4] + 4'h3;
            end
         end
         s = {s[28:0], 1'b0};
      end
      dsm_bcd = s[29:14];
   endfunction : dsm_bcd

   logic [1:0] menu_limit_setting_ff, nxt_menu_limit_setting;
   logic [3:0] item_ff, nxt_item;
   logic [15:0] speed_coefficient_ff, nxt_speed_coefficient;
   logic [15:0] pid_scale_coef_a_ff, nxt_pid_scale_coef_a;
   logic [15:0] pid_scale_coef_b_ff, nxt_pid_scale_coef_b;
   logic [15:0] uv_thresh_ff, nxt_uv_thresh;
   logic [31:0] prdata_ff, nxt_prdata;
   logic busy_ff, nxt_busy;
   logic [15:0] status_ff, nxt_status;
   logic [19:0] glyph_ff, nxt_glyph;
   logic [27:0] seg_ff, nxt_seg;
   logic cfg_hit, ro_hit, wr_en, link_voltage_ok, menu_full;

   // Address decode and handshake; every access completes without wait
   always_comb begin
      cfg_hit = (paddr == REG_CTRL) || (paddr == REG_SPEED_COEF) ||
                (paddr == REG_PID_A) || (paddr == REG_PID_B) ||
                (paddr == REG_UV_THRESH);
      ro_hit = (paddr == REG_STATUS) || (paddr == REG_DISPLAY);
      pready = psel && penable;
      pslverr = psel && penable && !(cfg_hit || ro_hit);
      wr_en = psel && penable && pwrite && cfg_hit;
   end

   // Settings registers, written at the completing access edge
   always_comb begin
      nxt_menu_limit_setting = menu_limit_setting_ff;
      nxt_item = item_ff;
      nxt_speed_coefficient = speed_coefficient_ff;
      nxt_pid_scale_coef_a = pid_scale_coef_a_ff;
      nxt_pid_scale_coef_b = pid_scale_coef_b_ff;
      nxt_uv_thresh = uv_thresh_ff;
      if (wr_en) begin
         case (paddr)
            REG_CTRL: begin
               nxt_menu_limit_setting = pwdata[CTRL_MENU_LSB +: 2];
               nxt_item = pwdata[CTRL_ITEM_LSB +: 4];
            end
            REG_SPEED_COEF: nxt_speed_coefficient = pwdata[15:0];
            REG_PID_A: nxt_pid_scale_coef_a = pwdata[15:0];
            REG_PID_B: nxt_pid_scale_coef_b = pwdata[15:0];
            REG_UV_THRESH: nxt_uv_thresh = pwdata[15:0];
            default: nxt_uv_thresh = uv_thresh_ff;
         endcase
      end
   end

   // Read data is latched in the setup cycle
   always_comb begin
      nxt_prdata = prdata_ff;
      if (psel && !penable && !pwrite) begin
         case (paddr)
            REG_CTRL: nxt_prdata = {20'h00000, item_ff, 6'h00,
                                    menu_limit_setting_ff};
            REG_SPEED_COEF: nxt_prdata = {16'h0000, speed_coefficient_ff};
            REG_PID_A: nxt_prdata = {16'h0000, pid_scale_coef_a_ff};
            REG_PID_B: nxt_prdata = {16'h0000, pid_scale_coef_b_ff};
            REG_UV_THRESH: nxt_prdata = {16'h0000, uv_thresh_ff};
            REG_STATUS: nxt_prdata = {16'h0000, status_ff};
            REG_DISPLAY: nxt_prdata = {12'h000, glyph_ff};
            default: nxt_prdata = 32'h0000_0000;
         endcase
      end
   end

   // Running-status word packing
   always_comb begin
      nxt_busy = psel && pwrite && cfg_hit; // [RL1]
      link_voltage_ok = dc_link_volts > uv_thresh_ff; // [RL6]
      nxt_status = 16'h0000; // [RL12]
      nxt_status[BIT_BUSY] = busy_ff; // [RL1]
      nxt_status[BIT_REMOTE] = remote_link_active; // [RL2]
      nxt_status[BIT_FAULT] = fault_active; // [RL3]
      nxt_status[BIT_DOWN] = ramping_down; // [RL11]
      nxt_status[BIT_UP] = ramping_up; // [RL11]
      nxt_status[BIT_ILIM] = current_limit_active; // [RL4]
      nxt_status[BIT_VLIM] = voltage_limit_active; // [RL5]
      nxt_status[BIT_VOK] = link_voltage_ok; // [RL6]
      nxt_status[BIT_STOP] = output_stopped; // [RL7]
      nxt_status[BIT_DCBRK] = dc_brake_active; // [RL8]
      nxt_status[BIT_REV] = running_backward; // [RL9]
      nxt_status[BIT_FWD] = running_ahead; // [RL10]
   end

   logic signed [16:0] pid_span;
   logic signed [33:0] pid_prod;
   logic signed [33:0] pid_val;
   logic [31:0] speed_val;
   logic [31:0] num_val;
   logic [15:0] bcd_val;
   logic show_num;

   // Selected item to glyphs; numbers pass through BCD conversion
   always_comb begin
      menu_full = menu_limit_setting_ff == MENU_FULL; // [RL21]
      speed_val = freq_pre_slip * speed_coefficient_ff; // [RL17]
      pid_span = 17'(signed'(pid_scale_coef_a_ff)) -
                 17'(signed'(pid_scale_coef_b_ff));
      pid_prod = signed'({1'b0, (item_ff == ITEM_PID_FB) ? pid_feedback :
                  pid_command}) * pid_span;
      // Scaled by A minus B, then offset by B
      pid_val = (pid_prod >>> PID_FRAC) +
                34'(signed'(pid_scale_coef_b_ff)); // [RL19] [RL20]
      num_val = 32'h0000_0000;
      show_num = 1'b0;
      nxt_glyph = {4{GLY_DASH}};
      case (item_ff)
         ITEM_FREQ_PRE: begin
            num_val = {16'h0000, freq_pre_slip}; // [RL14]
            show_num = 1'b1;
         end
         ITEM_FREQ_POST: begin
            num_val = {16'h0000, freq_post_slip}; // [RL15]
            show_num = 1'b1;
         end
         ITEM_DIRECTION: begin
            if (running_ahead) begin
               nxt_glyph = {GLY_BLANK, GLY_BLANK, GLY_BLANK, GLY_F}; // [RL16]
            end else if (running_backward) begin
               nxt_glyph = {GLY_BLANK, GLY_BLANK, GLY_BLANK, GLY_R}; // [RL16]
            end
         end
         ITEM_STATUS: begin
            // Top nibble lands on the leftmost digit
            nxt_glyph = {1'b0, status_ff[15:12], 1'b0, status_ff[11:8],
                         1'b0, status_ff[7:4], 1'b0, status_ff[3:0]}; // [RL13]
         end
         ITEM_SPEED: begin
            num_val = speed_val;
            show_num = 1'b1;
         end
         ITEM_PID_CMD, ITEM_PID_FB: begin
            if (pid_enabled) begin
               show_num = 1'b1;
               // Negative results cannot be shown and read as overflow
               num_val = pid_val[33] ? DISP_LIMIT :
                         (pid_val >= 34'(DISP_LIMIT)) ? DISP_LIMIT :
                         pid_val[31:0];
            end
         end
         default: nxt_glyph = {4{GLY_DASH}};
      endcase
      // Only values below the limit reach the digits, so 14 bits suffice
      bcd_val = dsm_bcd(num_val[13:0]);
      if (show_num) begin
         if (num_val >= DISP_LIMIT) begin
            nxt_glyph = {4{GLY_OVF}}; // [RL18]
         end else begin
            nxt_glyph = {1'b0, bcd_val[15:12], 1'b0, bcd_val[11:8],
                         1'b0, bcd_val[7:4], 1'b0, bcd_val[3:0]};
         end
      end
      if (!menu_full) begin
         nxt_glyph = {4{GLY_BLANK}}; // [RL21]
      end
   end

   // Glyph to segment pattern per digit
   genvar gd;
   generate
      for (gd = 0; gd < 4; gd++) begin : g_digit
         assign nxt_seg[7 * gd +: 7] = dsm_seg(nxt_glyph[5 * gd +: 5]); // [RL22]
      end
   endgenerate

   // State registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         menu_limit_setting_ff <= RST_MENU;
         item_ff <= RST_ITEM;
         speed_coefficient_ff <= RST_SPEED_COEF;
         pid_scale_coef_a_ff <= RST_PID_A;
         pid_scale_coef_b_ff <= RST_PID_B;
         uv_thresh_ff <= RST_UV_THRESH;
         prdata_ff <= 32'h0000_0000;
         busy_ff <= 1'b0;
         status_ff <= 16'h0000;
         glyph_ff <= {4{GLY_BLANK}};
         seg_ff <= 28'h0000000;
      end else begin
         menu_limit_setting_ff <= nxt_menu_limit_setting;
         item_ff <= nxt_item;
         speed_coefficient_ff <= nxt_speed_coefficient;
         pid_scale_coef_a_ff <= nxt_pid_scale_coef_a;
         pid_scale_coef_b_ff <= nxt_pid_scale_coef_b;
         uv_thresh_ff <= nxt_uv_thresh;
         prdata_ff <= nxt_prdata;
         busy_ff <= nxt_busy;
         status_ff <= nxt_status;
         glyph_ff <= nxt_glyph;
         seg_ff <= nxt_seg;
      end
   end

   // Outputs
   assign prdata = prdata_ff;
   assign running_status = status_ff;
   assign monitor_available = menu_full;
   assign led_glyphs = glyph_ff;
   assign led_segments = seg_ff;

   // Checks
   property p_busy;
      @(posedge pclk) disable iff (!presetn)
      (psel && pwrite && cfg_hit) |=> ##1 running_status[BIT_BUSY];
   endproperty
   a_busy: assert property (p_busy) else $error("busy bit missing"); // [RL1]

   property p_remote;
      @(posedge pclk) disable iff (!presetn)
      running_status[BIT_REMOTE] == $past(remote_link_active);
   endproperty
   a_remote: assert property (p_remote) // [RL2]
      else $error("remote bit wrong");

   property p_fault;
      @(posedge pclk) disable iff (!presetn)
      fault_active |=> running_status[BIT_FAULT];
   endproperty
   a_fault: assert property (p_fault) else $error("alarm bit wrong"); // [RL3]

   property p_limits;
      @(posedge pclk) disable iff (!presetn)
      ##1 (running_status[BIT_ILIM] == $past(current_limit_active)) &&
      (running_status[BIT_VLIM] == $past(voltage_limit_active));
   endproperty
   a_limits: assert property (p_limits) // [RL4] [RL5]
      else $error("limit bits wrong");

   property p_vok;
      @(posedge pclk) disable iff (!presetn)
      (dc_link_volts <= uv_thresh_ff) |=> !running_status[BIT_VOK];
   endproperty
   a_vok: assert property (p_vok) else $error("voltage bit wrong"); // [RL6]

   property p_motion;
      @(posedge pclk) disable iff (!presetn)
      ##1 running_status[3:0] == {$past(output_stopped),
      $past(dc_brake_active), $past(running_backward), $past(running_ahead)};
   endproperty
   a_motion: assert property (p_motion) // [RL7] [RL8] [RL9] [RL10]
      else $error("motion bits wrong");

   property p_ramp;
      @(posedge pclk) disable iff (!presetn)
      ##1 running_status[10:9] == {$past(ramping_down), $past(ramping_up)};
   endproperty
   a_ramp: assert property (p_ramp) else $error("ramp bits wrong"); // [RL11]

   property p_zero;
      @(posedge pclk) disable iff (!presetn)
      {running_status[14:13], running_status[6], running_status[4]} == 4'h0;
   endproperty
   a_zero: assert property (p_zero) // [RL12]
      else $error("fixed bits not zero");

   property p_hex;
      @(posedge pclk) disable iff (!presetn)
      (menu_full && item_ff == ITEM_STATUS) |=>
      led_glyphs[19:15] == {1'b0, $past(running_status[15:12])};
   endproperty
   a_hex: assert property (p_hex) else $error("hex digit wrong"); // [RL13]

   property p_overflow;
      @(posedge pclk) disable iff (!presetn)
      (menu_full && item_ff == ITEM_SPEED && speed_val >= DISP_LIMIT) |=>
      led_glyphs == {4{GLY_OVF}};
   endproperty
   a_overflow: assert property (p_overflow) // [RL17] [RL18]
      else $error("no overflow");

   property p_dir;
      @(posedge pclk) disable iff (!presetn)
      (menu_full && item_ff == ITEM_DIRECTION && running_ahead) |=>
      led_glyphs == {GLY_BLANK, GLY_BLANK, GLY_BLANK, GLY_F};
   endproperty
   a_dir: assert property (p_dir) else $error("direction wrong"); // [RL16]

   property p_pid_off;
      @(posedge pclk) disable iff (!presetn)
      (menu_full && !pid_enabled && (item_ff == ITEM_PID_CMD ||
      item_ff == ITEM_PID_FB)) |=> led_glyphs == {4{GLY_DASH}};
   endproperty
   a_pid_off: assert property (p_pid_off) // [RL19] [RL20]
      else $error("pid not dashed");

   property p_menu;
      @(posedge pclk) disable iff (!presetn)
      !menu_full |=> led_segments == 28'h0000000;
   endproperty
   a_menu: assert property (p_menu) else $error("menu not limited"); // [RL21]

   c_status: cover property (@(posedge pclk) disable iff (!presetn)
      menu_full && item_ff == ITEM_STATUS ##1 running_status != 16'h0000);
   c_speed_ovf: cover property (@(posedge pclk) disable iff (!presetn)
      led_glyphs == {4{GLY_OVF}});
   c_reverse: cover property (@(posedge pclk) disable iff (!presetn)
      menu_full && item_ff == ITEM_DIRECTION && running_backward);
endmodule : dsm_drive_status_monitor
`default_nettype wire

// File: dv/dsm_led_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module dsm_led_monitor
   import dsm_pkg::*;
(
   input wire logic [27:0] led_segments,
   output logic [19:0] shown
);
   // Patterns the panel recognises, indexed by glyph code
   localparam logic [6:0] PAT [20] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66,
      7'h6d, 7'h7d, 7'h07, 7'h7f, 7'h6f, 7'h77, 7'h7c, 7'h39, 7'h5e, 7'h79,
      7'h71, 7'h40, 7'h50, 7'h00, 7'h49};
   // Read each digit back as a glyph code, 5'h1f when unreadable
   always_comb begin
      shown = '1;
      for (int d = 0; d < 4; d++) begin
         for (int k = 0; k < 20; k++) begin
            if (led_segments[d*7 +: 7] == PAT[k]) begin
               shown[d*5 +: 5] = k[4:0];
            end
         end
      end
   end
endmodule : dsm_led_monitor
`default_nettype wire

// File: dv/dsm_drive_status_monitor_bench.sv
`timescale 1ns/100ps
`default_nettype none
module dsm_drive_status_monitor_bench
   import dsm_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pid_en;
   logic mon_av;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [9:0] flags;
   logic [15:0] volts, fpre, fpost, pid_cmd, pid_fb, status;
   logic [19:0] glyphs, shown;
   logic [27:0] segs;
   int fails = 0;
   int checked = 0;
   int cyc = 0;
   localparam logic [4:0] B = GLY_BLANK;
   localparam int POS [10] = '{0, 1, 2, 3, 7, 8, 9, 10, 11, 12};

   dsm_drive_status_monitor i_dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .remote_link_active(flags[9]), .fault_active(flags[8]),
      .ramping_down(flags[7]), .ramping_up(flags[6]),
      .current_limit_active(flags[5]), .voltage_limit_active(flags[4]),
      .output_stopped(flags[3]), .dc_brake_active(flags[2]),
      .running_backward(flags[1]), .running_ahead(flags[0]),
      .dc_link_volts(volts), .freq_pre_slip(fpre), .freq_post_slip(fpost),
      .pid_enabled(pid_en), .pid_command(pid_cmd), .pid_feedback(pid_fb),
      .running_status(status), .monitor_available(mon_av),
      .led_glyphs(glyphs), .led_segments(segs));
   dsm_led_monitor i_panel (.led_segments(segs), .shown(shown));

   // Clock at 100 MHz
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   // Hang guard
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         fails = fails + 1;
         end_of_test();
      end
   end

   task automatic chk(input string name, input logic [31:0] seen,
         input logic [31:0] exp);
      checked = checked + 1;
      if (seen !== exp) begin
         fails = fails + 1;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   // One APB transfer, held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a,
         input logic [31:0] d, output logic [31:0] q, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask : wr_reg

   task automatic settle();
      repeat (4) @(posedge pclk);
   endtask : settle

   // Compare glyph codes and what the panel decodes
   task automatic disp(input string name, input logic [19:0] exp);
      chk(name, glyphs, exp);
      chk(name, shown, exp);
   endtask : disp

   task automatic t_reset();
      logic [7:0] ra [5];
      logic [31:0] rv [5];
      logic [31:0] q;
      logic e;
      ra = '{REG_CTRL, REG_SPEED_COEF, REG_PID_A, REG_PID_B, REG_UV_THRESH};
      rv = '{32'h0, 32'h1, 32'h64, 32'h0, 32'hc8};
      chk("avail", mon_av, 32'h0);
      disp("blank", {4{B}});
      for (int i = 0; i < 5; i++) begin
         apb(1'b0, ra[i], 32'h0, q, e);
         chk("reset value", q, rv[i]);
         chk("err", e, 32'h0);
      end
      apb(1'b0, 8'h1c, 32'h0, q, e);
      chk("unmapped err", e, 32'h1);
      chk("unmapped data", q, 32'h0);
   endtask : t_reset

   task automatic t_bits();
      logic [31:0] q;
      logic e;
      for (int j = 0; j < 10; j++) begin
         flags <= 10'h1 << j;
         settle();
         chk("status", status, 32'h1 << POS[j]);
      end
      flags <= '1;
      settle();
      chk("all flags", status, 32'h1f8f);
      wr_reg(REG_UV_THRESH, 32'h0100);
      volts <= 16'h0100;
      settle();
      chk("at threshold", status, 32'h1f8f);
      volts <= 16'h0101;
      settle();
      chk("above threshold", status, 32'h1faf);
      apb(1'b0, REG_STATUS, 32'h0, q, e);
      chk("status read", q, 32'h1faf);
      flags <= '0;
      volts <= '0;
   endtask : t_bits

   task automatic t_busy();
      logic hit;
      hit = 1'b0;
      fork
         wr_reg(REG_SPEED_COEF, 32'h1);
         repeat (6) begin
            @(posedge pclk);
            if (status[15] === 1'b1) hit = 1'b1;
         end
      join
      chk("busy seen", hit, 32'h1);
      settle();
      chk("busy clear", status[15], 32'h0);
   endtask : t_busy

   task automatic t_hex();
      wr_reg(REG_CTRL, 32'h0702);
      settle();
      chk("avail", mon_av, 32'h1);
      for (logic [4:0] n = 0; n < 16; n++) begin
         flags <= {1'b1, n[3:0], 5'h0};
         settle();
         disp("hex", {5'h01, 1'b0, n[3:0], 5'h00, 5'h00});
      end
      flags <= '0;
   endtask : t_hex

   task automatic t_freq();
      fpre <= 16'h04d2;
      fpost <= 16'h162e;
      wr_reg(REG_CTRL, 32'h0002);
      settle();
      disp("freq pre", {5'h1, 5'h2, 5'h3, 5'h4});
      wr_reg(REG_CTRL, 32'h0102);
      settle();
      disp("freq post", {5'h5, 5'h6, 5'h7, 5'h8});
   endtask : t_freq

   task automatic t_dir();
      wr_reg(REG_CTRL, 32'h0602);
      flags <= 10'h001;
      settle();
      disp("forward", {B, B, B, GLY_F});
      flags <= 10'h002;
      settle();
      disp("reverse", {B, B, B, GLY_R});
      flags <= 10'h008;
      settle();
      disp("stopped", {4{GLY_DASH}});
      flags <= '0;
   endtask : t_dir

   task automatic t_speed();
      wr_reg(REG_SPEED_COEF, 32'h3);
      wr_reg(REG_CTRL, 32'h0902);
      settle();
      disp("speed", {5'h3, 5'h7, 5'h0, 5'h2});
      fpre <= 16'h0d05;
      settle();
      disp("speed max", {4{5'h9}});
      fpre <= 16'h0d06;
      settle();
      disp("speed over", {4{GLY_OVF}});
   endtask : t_speed

   task automatic t_pid();
      wr_reg(REG_PID_A, 32'h2328);
      wr_reg(REG_PID_B, 32'h03e8);
      pid_en <= 1'b1;
      pid_cmd <= 16'h4000;
      pid_fb <= 16'h2000;
      wr_reg(REG_CTRL, 32'h0a02);
      settle();
      disp("pid cmd", {5'h5, 5'h0, 5'h0, 5'h0});
      wr_reg(REG_CTRL, 32'h0b02);
      settle();
      disp("pid fb", {5'h3, 5'h0, 5'h0, 5'h0});
      pid_en <= 1'b0;
      settle();
      disp("pid fb off", {4{GLY_DASH}});
      wr_reg(REG_CTRL, 32'h0a02);
      settle();
      disp("pid cmd off", {4{GLY_DASH}});
   endtask : t_pid

   task automatic t_menu();
      for (int m = 0; m < 4; m++) begin
         if (m != 2) begin
            wr_reg(REG_CTRL, 32'h0700 | 32'(m));
            settle();
            chk("avail", mon_av, 32'h0);
            disp("menu blank", {4{B}});
         end
      end
   endtask : t_menu

   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_of_test

   // Main sequence
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, pid_en} = '0;
      paddr = '0;
      pwdata = '0;
      flags = '0;
      {volts, fpre, fpost, pid_cmd, pid_fb} = '0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_bits();
      t_busy();
      t_hex();
      t_freq();
      t_dir();
      t_speed();
      t_pid();
      t_menu();
      end_of_test();
   end
endmodule : dsm_drive_status_monitor_bench
`default_nettype wire
